// >>> rtl/timer_pwm_capture_defs.svh
`ifndef TIMER_PWM_CAPTURE_DEFS_SVH
`define TIMER_PWM_CAPTURE_DEFS_SVH

// register byte offsets
`define TPC_OFS_CTRL    8'h00
`define TPC_OFS_COUNT   8'h04
`define TPC_OFS_RELOAD  8'h08
`define TPC_OFS_PWM     8'h0c
`define TPC_OFS_STATUS  8'h10
`define TPC_OFS_MASK    8'h14

// control field positions
`define TPC_CTRL_EN_BIT    0
`define TPC_CTRL_MODE_BIT  1
`define TPC_CTRL_POL_BIT   2
`define TPC_CTRL_PRE_LSB   3
`define TPC_CTRL_PRE_MSB   5

// status and mask field positions
`define TPC_STS_RELOAD_BIT  0
`define TPC_STS_CAPTURE_BIT 1

// reset values
`define TPC_RST_CTRL    6'h00
`define TPC_RST_COUNT   16'h0001
`define TPC_RST_RELOAD  16'hffff
`define TPC_RST_PWM     16'h0000
`define TPC_RST_STATUS  2'h0
`define TPC_RST_MASK    2'h0

// counter restart value after reaching reload
`define TPC_COUNT_START 16'h0001
`endif

// >>> rtl/timer_pwm_capture_pkg.sv
package timer_pwm_capture_pkg;

	typedef enum logic {
		mode_pwm,
		mode_capture
	} timer_mode_e;

	typedef struct packed {
		logic [2:0]  prescale;
		logic        timer_polarity_bit;
		timer_mode_e mode;
		logic        enable;
	} ctrl_s;

	typedef struct packed {
		logic capture;
		logic reload;
	} events_s;

endpackage

// >>> rtl/timer_pwm_capture.sv
`include "timer_pwm_capture_defs.svh"

module timer_pwm_capture #(
	parameter int CNT_W   = 16,
	parameter int PRESC_W = 3
) (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic        timer_in,
	output logic             pwm_out,
	output logic             irq_out
);

	localparam int DIV_W = (1 << PRESC_W) - 1;

	// the byte-lane merge and the divider are sized for these values only
	if (CNT_W != 16 || PRESC_W < 1 || PRESC_W > 3) begin : g_bad_width
		$error("timer_pwm_capture: only CNT_W=16 and PRESC_W 1..3 are served");
	end

	timer_pwm_capture_pkg::ctrl_s   ctrl_r;
	timer_pwm_capture_pkg::events_s status_r;
	timer_pwm_capture_pkg::events_s mask_r;
	timer_pwm_capture_pkg::events_s evt;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] reload_r;
	logic [CNT_W-1:0] pwm_val_r;
	logic [DIV_W-1:0] div_r;
	logic [DIV_W-1:0] div_top;
	logic             tick;
	logic             at_reload;
	logic             tin_prev_r;
	logic             cap_edge;
	logic             first_r;
	logic             req;
	logic             wr_fire;
	logic             wr_ctrl;
	logic             wr_count;
	logic             wr_reload;
	logic             wr_pwm;
	logic             wr_status;
	logic             wr_mask;
	logic [31:0]      rd_nxt;
	logic             pwm_nxt;
	logic [1:0]       status_nxt;
	logic             running;
	logic             in_capture;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		merge16 = old;
		if (sel[0]) begin
			merge16[7:0] = d[7:0];
		end
		if (sel[1]) begin
			merge16[15:8] = d[15:8];
		end
	endfunction

	// bus: ack one cycle after the request; writes commit on the ack edge
	assign req       = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr_fire   = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
	assign wr_ctrl   = wr_fire && wb_adr_in == `TPC_OFS_CTRL && wb_sel_in[0];
	assign wr_count  = wr_fire && wb_adr_in == `TPC_OFS_COUNT && |wb_sel_in[1:0];
	assign wr_reload = wr_fire && wb_adr_in == `TPC_OFS_RELOAD && |wb_sel_in[1:0];
	assign wr_pwm    = wr_fire && wb_adr_in == `TPC_OFS_PWM && |wb_sel_in[1:0];
	assign wr_status = wr_fire && wb_adr_in == `TPC_OFS_STATUS && wb_sel_in[0];
	assign wr_mask   = wr_fire && wb_adr_in == `TPC_OFS_MASK && wb_sel_in[0];

	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (wb_adr_in)
			`TPC_OFS_CTRL:   rd_nxt[5:0] = ctrl_r;
			`TPC_OFS_COUNT:  rd_nxt[15:0] = count_r;
			`TPC_OFS_RELOAD: rd_nxt[15:0] = reload_r;
			`TPC_OFS_PWM:    rd_nxt[15:0] = pwm_val_r;
			`TPC_OFS_STATUS: rd_nxt[1:0] = status_r;
			`TPC_OFS_MASK:   rd_nxt[1:0] = mask_r;
			default:         rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= req;
			if (req) begin
				wb_dat_out <= rd_nxt;
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl_r   <= `TPC_RST_CTRL;
			reload_r <= `TPC_RST_RELOAD;
			mask_r   <= `TPC_RST_MASK;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= wb_dat_in[5:0];
			end
			if (wr_reload) begin
				reload_r <= merge16(reload_r, wb_dat_in, wb_sel_in);
			end
			if (wr_mask) begin
				mask_r <= wb_dat_in[1:0];
			end
		end
	end

	// prescaler: divide by 2^prescale, held clear while disabled
	assign running    = ctrl_r.enable;
	assign in_capture = ctrl_r.mode == timer_pwm_capture_pkg::mode_capture;
	assign div_top    = DIV_W'((1 << ctrl_r.prescale) - 1);
	assign tick       = running && div_r >= div_top;
	assign at_reload  = count_r == reload_r;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			div_r <= '0;
		end else if (!running || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// counter advances only on prescaled system clock ticks; timer_in never clocks it
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			count_r <= `TPC_RST_COUNT;
		end else if (wr_count) begin
			count_r <= merge16(count_r, wb_dat_in, wb_sel_in);
		end else if (tick) begin
			if (at_reload) begin
				count_r <= `TPC_COUNT_START;
			end else begin
				count_r <= count_r + 1'b1;
			end
		end
	end

	// a start value other than one makes the first period a one-shot run to reload
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			first_r <= 1'b0;
		end else if (wr_ctrl && !ctrl_r.enable && wb_dat_in[`TPC_CTRL_EN_BIT]) begin
			first_r <= count_r != `TPC_COUNT_START;
		end else if (tick && at_reload) begin
			first_r <= 1'b0;
		end
	end

	// timer_in is synchronous, so one stage of history gives the edge
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tin_prev_r <= 1'b0;
		end else begin
			tin_prev_r <= timer_in;
		end
	end

	assign cap_edge = ctrl_r.timer_polarity_bit ? (tin_prev_r && !timer_in) :
		(!tin_prev_r && timer_in);
	// one driver for the whole struct keeps strict tools quiet
	always_comb begin
		evt.capture = running && in_capture && cap_edge;
		evt.reload  = tick && at_reload;
	end

	// capture wins over a software write in the same cycle so no event is lost
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pwm_val_r <= `TPC_RST_PWM;
		end else if (evt.capture) begin
			pwm_val_r <= count_r;
		end else if (wr_pwm) begin
			pwm_val_r <= merge16(pwm_val_r, wb_dat_in, wb_sel_in);
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_comb begin
		status_nxt = status_r;
		if (wr_status) begin
			status_nxt = status_r & ~wb_dat_in[1:0];
		end
		status_nxt = status_nxt | evt;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			status_r <= `TPC_RST_STATUS;
			irq_out  <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_out  <= |(status_nxt & mask_r);
		end
	end

	// output held low through a one-shot first period, then compare against pwm value
	always_comb begin
		pwm_nxt = 1'b0;
		if (running && !in_capture && !first_r) begin
			if (ctrl_r.timer_polarity_bit) begin
				pwm_nxt = count_r <= pwm_val_r;
			end else begin
				pwm_nxt = count_r > pwm_val_r;
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pwm_out <= 1'b0;
		end else begin
			pwm_out <= pwm_nxt;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence s_bus_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence

	sequence s_ack_pulse;
		wb_ack_out ##1 !wb_ack_out;
	endsequence

	property p_bus_ack;
		s_bus_req |=> s_ack_pulse;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("bus ack not a single pulse");

	property p_restart_one;
		tick && at_reload && !wr_count |=> count_r == 16'h0001;
	endproperty
	a_restart_one: assert property (p_restart_one) else $error("count not restarted at one");

	property p_count_up;
		tick && !at_reload && !wr_count |=> count_r == $past(count_r) + 16'h0001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("count did not advance");

	property p_hold_no_tick;
		!tick && !wr_count |=> $stable(count_r);
	endproperty
	a_hold_no_tick: assert property (p_hold_no_tick) else $error("count moved without tick");

	property p_capture_value;
		evt.capture |=> pwm_val_r == $past(count_r);
	endproperty
	a_capture_value: assert property (p_capture_value) else $error("capture value wrong");

	property p_capture_irq;
		evt.capture && mask_r.capture |=> status_r.capture && irq_out;
	endproperty
	a_capture_irq: assert property (p_capture_irq) else $error("capture irq missing");

	property p_reload_irq;
		evt.reload |=> status_r.reload;
	endproperty
	a_reload_irq: assert property (p_reload_irq) else $error("reload status missing");

	property p_edge_select;
		running && in_capture && !ctrl_r.timer_polarity_bit && !tin_prev_r && timer_in
			|-> evt.capture;
	endproperty
	a_edge_select: assert property (p_edge_select) else $error("rising edge not captured");

	property p_pwm_pol0;
		running && !in_capture && !first_r && !ctrl_r.timer_polarity_bit
			&& count_r > pwm_val_r |=> pwm_out;
	endproperty
	a_pwm_pol0: assert property (p_pwm_pol0) else $error("pwm high phase wrong");

	property p_pwm_pol1;
		running && !in_capture && !first_r && ctrl_r.timer_polarity_bit
			&& count_r > pwm_val_r |=> !pwm_out;
	endproperty
	a_pwm_pol1: assert property (p_pwm_pol1) else $error("pwm low phase wrong");

	property p_first_hold;
		first_r |=> !pwm_out;
	endproperty
	a_first_hold: assert property (p_first_hold) else $error("pwm active in one-shot period");

	property p_first_set;
		wr_ctrl && !ctrl_r.enable && wb_dat_in[`TPC_CTRL_EN_BIT] && count_r != 16'h0001
			|=> first_r;
	endproperty
	a_first_set: assert property (p_first_set) else $error("one-shot not armed");

	property p_edge_ignore;
		running && in_capture && !ctrl_r.timer_polarity_bit && tin_prev_r && !timer_in
			|-> !evt.capture;
	endproperty
	a_edge_ignore: assert property (p_edge_ignore) else $error("falling edge captured");

	property p_edge_fall;
		running && in_capture && ctrl_r.timer_polarity_bit && tin_prev_r && !timer_in
			|-> evt.capture;
	endproperty
	a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed");

	property p_pwm_val_hold;
		!evt.capture && !wr_pwm |=> $stable(pwm_val_r);
	endproperty
	a_pwm_val_hold: assert property (p_pwm_val_hold) else $error("pwm value moved");

	property p_status_sticky;
		status_r.capture && !(wr_status && wb_dat_in[`TPC_STS_CAPTURE_BIT]) |=> status_r.capture;
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

	// irq follows the mask one clock late because it is registered
	property p_irq_level;
		irq_out == |(status_r & $past(mask_r));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	property p_pwm_quiet;
		in_capture |=> !pwm_out;
	endproperty
	a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm active in capture");

	property p_tick_spacing;
		tick && ctrl_r.prescale != 3'h0 && !wr_ctrl |=> !tick;
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("double tick");

endmodule

// >>> verification/timer_src.sv
module timer_src (
	input  wire logic clk_in,
	input  wire logic level_in,
	output logic      timer_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// registered like a real pin, so every edge lands just after a clock edge
	always_ff @(posedge clk_in) begin
		timer_out <= level_in;
	end
endmodule

// >>> verification/timer_pwm_capture_test.sv
module timer_pwm_capture_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic [3:0]  wb_sel = 4'hf;
	logic [3:0]  bsel = 4'hf;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        pwm;
	logic        irq;
	logic        tin;
	logic        lvl = 1'b0;
	logic [31:0] d;
	logic [31:0] c0;
	logic [31:0] c1;
	int          fails = 0;
	int          comparisons = 0;
	int          hi;
	logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
	logic [31:0] rv [7] = '{32'h0, 32'h1, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0};

	always #25 clk_in = ~clk_in;

	timer_src src (
		.clk_in   (clk_in),
		.level_in (lvl),
		.timer_out(tin)
	);

	// stb rides with cyc: the classic single cycle never splits them
	timer_pwm_capture uut (
		.clk_in    (clk_in),
		.sys_rst_in(sys_rst_in),
		.wb_cyc_in (wb_cyc),
		.wb_stb_in (wb_cyc),
		.wb_we_in  (wb_we),
		.wb_adr_in (wb_adr),
		.wb_sel_in (wb_sel),
		.wb_dat_in (wb_wdat),
		.wb_dat_out(wb_rdat),
		.wb_ack_out(wb_ack),
		.timer_in  (tin),
		.pwm_out   (pwm),
		.irq_out   (irq)
	);

	task automatic end_of_test;
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] v,
		output logic [31:0] r);
		@(posedge clk_in);
		wb_cyc  <= 1'b1;
		wb_we   <= we;
		wb_adr  <= a;
		wb_wdat <= v;
		wb_sel  <= bsel;
		do @(posedge clk_in); while (wb_ack !== 1'b1);
		r = wb_rdat;
		wb_cyc <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] r;
		bus(1'b1, a, v, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// counts clocks with the pwm output high
	task automatic meas(input int n, output int h);
		h = 0;
		repeat (n) begin
			@(posedge clk_in);
			if (pwm === 1'b1)
				h++;
		end
	endtask

	task automatic drive(input logic v);
		@(posedge clk_in);
		lvl <= v;
		wait_n(3);
	endtask

	initial begin
		wait_n(2);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], d);
			chk(d, rv[i], "reset value");
		end
		bsel = 4'h2;
		wr(8'h08, 32'h0000_ab00);
		bsel = 4'h1;
		wr(8'h08, 32'h0000_0012);
		bsel = 4'hf;
		rd(8'h08, d);
		chk(d, 32'h0000_ab12, "reload byte lanes");
		wr(8'h08, 32'h10);
		wr(8'h0c, 32'h4);
		for (int p = 0; p < 2; p++) begin
			wr(8'h04, 32'h1);
			wr(8'h00, 32'h1 | (p << 2));
			wait_n(20);
			// 32 clocks are exactly two periods of 16, whatever the phase
			meas(32, hi);
			chk(hi, (p == 1) ? 32'd8 : 32'd24, "pwm high time");
			wr(8'h00, 32'h0);
		end
		wr(8'h04, 32'h8);
		wr(8'h00, 32'h1);
		meas(7, hi);
		chk(hi, 32'd0, "one-shot first period");
		wait_n(10);
		meas(32, hi);
		chk(hi, 32'd24, "pwm after one-shot");
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h3);
		wait_n(40);
		rd(8'h10, d);
		chk(d & 32'h1, 32'h1, "reload status");
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(8'h14, 32'h1);
		wait_n(2);
		chk({31'h0, irq}, 32'h1, "reload irq");
		rd(8'h04, d);
		chk(d >= 32'h1 && d <= 32'h10, 32'h1, "count wraps");
		wr(8'h00, 32'h0);
		wr(8'h10, 32'h3);
		rd(8'h10, d);
		chk(d, 32'h0, "status cleared");
		wr(8'h14, 32'h2);
		wr(8'h08, 32'hffff);
		wr(8'h04, 32'h1);
		wr(8'h0c, 32'h0);
		wr(8'h00, 32'h3a);
		wr(8'h00, 32'h3b);
		wait_n(300);
		rd(8'h04, c0);
		drive(1'b1);
		rd(8'h0c, d);
		rd(8'h04, c1);
		chk(d >= c0 && d <= c1 && d != 0, 32'h1, "captured count");
		chk({31'h0, irq}, 32'h1, "capture irq");
		wait_n(300);
		rd(8'h04, d);
		// prescale 7 ticks every 128 clocks; timer_in holds still meanwhile
		chk(d - c1 >= 2 && d - c1 <= 3, 32'h1, "count keeps running");
		wr(8'h0c, 32'h0);
		wr(8'h10, 32'h3);
		drive(1'b0);
		rd(8'h0c, d);
		chk(d, 32'h0, "falling edge ignored");
		chk({31'h0, irq}, 32'h0, "no irq");
		wr(8'h00, 32'h3f);
		drive(1'b1);
		rd(8'h0c, d);
		chk(d, 32'h0, "rising edge ignored");
		drive(1'b0);
		rd(8'h0c, d);
		chk(d != 0, 32'h1, "falling edge captured");
		wr(8'h10, 32'h2);
		wait_n(2);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		end_of_test;
	end

	initial begin
		#500000;
		fails++;
		end_of_test;
	end
endmodule
